// File: bench/emig_chk.sv
// emig_chk.sv: port assertions for the interrupt group block.
// assumes: bound to emig_top, one clock, synchronous active-low reset.
`timescale 1ns/1ps
module emig_chk
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [2:0]  gp_timer_compare_match,
    input wire logic [2:0]  gp_timer_compare_action,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // answers stand until taken
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address taken while held");
    // action only for a match seen the cycle before
    a_cmp_action: assert property ((gp_timer_compare_action
        & ~$past(gp_timer_compare_match)) == 3'b000) else $error("action without match");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(irq));
    c_cmp: cover property (|gp_timer_compare_action);
endmodule // emig_chk
bind emig_top emig_chk chk (.*);

// File: bench/emig_cpu.sv
// emig_cpu.sv: core model that takes the block's level interrupt.
// assumes: irq is a level in the aclk domain.
`timescale 1ns/1ps
module emig_cpu
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       irq,
    output logic      [7:0] takes
);
    logic prev;
    // each new assertion is taken once; a level held high is not retaken
    always @(posedge aclk)
    begin
        prev <= irq;
        if (!aresetn)
            takes <= '0;
        else if (irq && !prev)
            takes <= takes + 8'h01;
    end
endmodule // emig_cpu

// File: bench/test_event_manager_interrupt_groups.sv
// test_event_manager_interrupt_groups.sv: self-checking bench of emig_top.
// assumes: emig_chk bound to the design, emig_cpu takes irq.
`timescale 1ns/1ps
`define CHK(a,e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module test_event_manager_interrupt_groups;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic        s_axi_arvalid = '0, s_axi_rready = '0;
    logic [16:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0, gp_timer_compare_match = '0;
    logic [3:0]  s_axi_wstrb = 4'hF, evt_group_c = '0, inj = '0;
    logic [10:0] evt_group_a = '0;
    logic [7:0]  evt_group_b = '0, takes;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire         s_axi_rvalid, irq;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [2:0]  group_irq_req, gp_timer_compare_action;
    int          mismatches = 0, tests_run = 0, cycles = 0;
    logic [31:0] d;
    logic [1:0]  r;
    // rows: register index, value read back after writing all ones
    logic [30:0] rows [7] = '{{15'h742C, 16'h07FF}, {15'h742D, 16'h00FF},
        {15'h742E, 16'h000F}, {15'h7432, 16'h0000}, {15'h7436, 16'h0002},
        {15'h743A, 16'h0007}, {15'h7439, 16'h0000}};
    emig_top uut (.*);
    emig_cpu cpu (.aclk(aclk), .aresetn(aresetn), .irq(irq), .takes(takes));
    // sticky record of compare action pulses, which last one cycle only
    logic [2:0]  acts = '0;
    always @(posedge aclk)
        if (aresetn)
            acts <= acts | gp_timer_compare_action;
    always #2.5 aclk = ~aclk;
    // hang guard, well above the run's length
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            results;
        end
    end
    task results;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // inj lands on the capture-four..one events in the write's execute cycle
    task wr(input [14:0] i, input [15:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(negedge aclk);
        while (!(s_axi_awready && s_axi_wready)) @(negedge aclk);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        evt_group_c <= inj;
        @(posedge aclk);
        evt_group_c <= '0;
        @(negedge aclk);
        while (!s_axi_bvalid) @(negedge aclk);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input [14:0] i);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge aclk);
        while (!s_axi_arready) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(negedge aclk);
        while (!s_axi_rvalid) @(negedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    // one-cycle event pulses, then time for status and the core to follow
    task pulse(input [10:0] a, input [7:0] b, input [3:0] c, input [2:0] m);
        @(posedge aclk);
        evt_group_a <= a;
        evt_group_b <= b;
        evt_group_c <= c;
        gp_timer_compare_match <= m;
        @(posedge aclk);
        evt_group_a <= '0;
        evt_group_b <= '0;
        evt_group_c <= '0;
        gp_timer_compare_match <= '0;
        repeat (3) @(negedge aclk);
    endtask
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 9; k++)
        begin
            rd(15'h742C + k[14:0]);
            `CHK(d, 32'h0000_0000)
        end
        `CHK(group_irq_req, 3'b000)
        foreach (rows[k])
        begin
            wr(rows[k][30:16], 16'hFFFF);
            rd(rows[k][30:16]);
            `CHK(d[15:0], rows[k][15:0])
        end
        pulse(11'h7FF, 8'h00, 4'h0, 3'b000);
        `CHK(group_irq_req, 3'b001)
        `CHK({irq, takes}, 9'h101)
        rd(15'h742F);
        `CHK(d, 32'h0000_06FF)
        rd(15'h7432);
        `CHK(d, 32'h0000_0001)
        wr(15'h742F, 16'h0001);
        rd(15'h7432);
        `CHK(d, 32'h0000_0002)
        pulse(11'h000, 8'hFF, 4'h0, 3'b110);
        `CHK(acts, 3'b010)
        rd(15'h7430);
        `CHK(d, 32'h0000_00DF)
        rd(15'h7433);
        `CHK(d, 32'h0000_0010)
        wr(15'h7439, 16'h0007);
        rd(15'h7438);
        `CHK({irq, d}, 33'h0_0000_0000)
        wr(15'h743A, 16'h0000);
        wr(15'h742E, 16'h0000);
        pulse(11'h000, 8'h00, 4'h8, 3'b000);
        `CHK(group_irq_req[2], 1'b0)
        rd(15'h7434);
        `CHK(d, 32'h0000_0000)
        wr(15'h742E, 16'h0008);
        rd(15'h7438);
        `CHK({irq, group_irq_req[2], d}, 34'h1_0000_0004)
        rd(15'h7434);
        `CHK(d, 32'h0000_0023)
        wr(15'h743A, 16'h0004);
        `CHK(irq, 1'b1)
        // a clear meeting a new capture event must lose
        inj = 4'h8;
        wr(15'h7431, 16'h0008);
        inj = 4'h0;
        rd(15'h7431);
        `CHK(d, 32'h0000_0008)
        wr(15'h7431, 16'h0008);
        rd(15'h7434);
        `CHK(d, 32'h0000_0000)
        rd(15'h7440);
        `CHK({r, d}, 34'h2_0000_0000)
        wr(15'h7440, 16'hFFFF);
        `CHK(r, 2'h2)
        // mid-run reset with a pending flag must clear everything
        pulse(11'h001, 8'h00, 4'h0, 3'b000);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK({irq, group_irq_req, takes}, 12'h000)
        rd(15'h742C);
        `CHK(d, 32'h0000_0000)
        rd(15'h742F);
        `CHK(d, 32'h0000_0000)
        results;
    end
endmodule // test_event_manager_interrupt_groups

// File: logic/emig_defs.vh
// emig_defs.vh: constants for the event manager interrupt group block.
// assumes: included by emig_top.v only; register offsets are word indices.
// What this block does
// - group request high while flag set and unmasked
// - vector read gives highest-priority pending identifier
// - vector reads zero with nothing pending
// - three read-only vectors, six-bit identifier, upper zero
// - group A mask holds eleven enable bits
// - group B mask holds timers three and two
// - group C mask holds capture four to one
// - group A flags: timer one, compares, protect
// - group B flags: timers three and two
// - group C flags: capture four to one
// - timer compare flag only while compare enabled
`ifndef EMIG_DEFS_VH
`define EMIG_DEFS_VH

// register indices; byte address is four times the index
`define EMIG_IDX_MASK_A     15'h742C
`define EMIG_IDX_MASK_B     15'h742D
`define EMIG_IDX_MASK_C     15'h742E
`define EMIG_IDX_FLAG_A     15'h742F
`define EMIG_IDX_FLAG_B     15'h7430
`define EMIG_IDX_FLAG_C     15'h7431
`define EMIG_IDX_VEC_A      15'h7432
`define EMIG_IDX_VEC_B      15'h7433
`define EMIG_IDX_VEC_C      15'h7434
`define EMIG_IDX_TCTL_1     15'h7435
`define EMIG_IDX_TCTL_2     15'h7436
`define EMIG_IDX_TCTL_3     15'h7437
`define EMIG_IDX_IRQ_STAT   15'h7438
`define EMIG_IDX_IRQ_CLR    15'h7439
`define EMIG_IDX_IRQ_EN     15'h743A

// implemented bits per group, packed {c, b, a}
`define EMIG_VALID_ALL      48'h000F_00FF_07FF
// identifier base per group, six bits each, packed {c, b, a}; id = base + bit
// c = 6'h20, b = 6'h10, a = 6'h01; hex digits do not fall on six-bit fields
`define EMIG_ID_BASE_ALL    18'h20401
`define EMIG_ID_NONE        6'h00

// compare enable position inside each timer control word
`define EMIG_TCTL_CMP_EN    1
`define EMIG_RST_16         16'h0000

`define EMIG_RESP_OKAY      2'h0
`define EMIG_RESP_SLVERR    2'h2

`endif

// File: logic/emig_top.v
// emig_top.v: interrupt grouping of the event manager, axi4-lite slave.
// assumes: one clock aclk, event inputs are one-cycle pulses in aclk domain.
`timescale 1ns/1ps
`include "emig_defs.vh"

module emig_top
(
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [16:0]  s_axi_awaddr,
    input  wire [2:0]   s_axi_awprot,
    input  wire         s_axi_awvalid,
    output wire         s_axi_awready,
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    input  wire         s_axi_wvalid,
    output wire         s_axi_wready,
    output reg  [1:0]   s_axi_bresp,
    output reg          s_axi_bvalid,
    input  wire         s_axi_bready,
    input  wire [16:0]  s_axi_araddr,
    input  wire [2:0]   s_axi_arprot,
    input  wire         s_axi_arvalid,
    output wire         s_axi_arready,
    output reg  [31:0]  s_axi_rdata,
    output reg  [1:0]   s_axi_rresp,
    output reg          s_axi_rvalid,
    input  wire         s_axi_rready,
    input  wire [10:0]  evt_group_a,
    input  wire [7:0]   evt_group_b,
    input  wire [3:0]   evt_group_c,
    input  wire [2:0]   gp_timer_compare_match,
    output wire [2:0]   group_irq_req,
    output reg  [2:0]   gp_timer_compare_action,
    output wire         irq
);

    // write channel holding registers
    reg                 aw_held;
    reg  [14:0]         aw_idx;
    reg                 w_held;
    reg  [15:0]         w_data;
    reg  [1:0]          w_strb;
    // timer control words, only the compare enable is kept
    reg  [2:0]          tctl_cmp_en;
    // block interrupt status, enable
    reg  [2:0]          irq_stat;
    reg  [2:0]          irq_en;
    reg  [2:0]          req_prev;

    wire                wr_fire;
    wire [15:0]         byte_mask;
    wire [15:0]         wr_bits;
    wire [2:0]          cmp_hit;
    wire [47:0]         evt_all;
    wire [47:0]         flag_all;
    wire [47:0]         mask_all;
    wire [17:0]         vec_all;
    wire [2:0]          req_rise;
    wire [14:0]         rd_idx;

    reg  [2:0]          wr_mask_sel;
    reg  [2:0]          wr_flag_sel;
    reg                 wr_tctl;
    reg  [1:0]          wr_tctl_num;
    reg                 wr_clr;
    reg                 wr_en;
    reg                 wr_ok;
    reg  [15:0]         rd_word;
    reg                 rd_ok;

    // both halves must be present; one write in flight at a time
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
    assign byte_mask     = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    assign wr_bits       = w_data & byte_mask;
    assign rd_idx        = s_axi_araddr[16:2];

    // compare flags and actions pass only while compare is enabled
    assign cmp_hit = gp_timer_compare_match & tctl_cmp_en;

    // event placement into each group's flag word
    // timer one compare sits at bit eight; that event pin bit is unused
    assign evt_all[15:0]  = {5'h00, evt_group_a[10:9], cmp_hit[0], evt_group_a[7:0]};
    assign evt_all[31:16] = {8'h00, evt_group_b[7:6], cmp_hit[2], evt_group_b[4:2],
                             cmp_hit[1], evt_group_b[0]};
    assign evt_all[47:32] = {12'h000, evt_group_c};

    // write address decode
    always @*
    begin
        wr_mask_sel = 3'b000;
        wr_flag_sel = 3'b000;
        wr_tctl     = 1'b0;
        wr_tctl_num = 2'd0;
        wr_clr      = 1'b0;
        wr_en       = 1'b0;
        wr_ok       = 1'b1;
        case (aw_idx)
            `EMIG_IDX_MASK_A:   wr_mask_sel = 3'b001;
            `EMIG_IDX_MASK_B:   wr_mask_sel = 3'b010;
            `EMIG_IDX_MASK_C:   wr_mask_sel = 3'b100;
            `EMIG_IDX_FLAG_A:   wr_flag_sel = 3'b001;
            `EMIG_IDX_FLAG_B:   wr_flag_sel = 3'b010;
            `EMIG_IDX_FLAG_C:   wr_flag_sel = 3'b100;
            // vectors are read-only; writes accepted and dropped
            `EMIG_IDX_VEC_A,
            `EMIG_IDX_VEC_B,
            `EMIG_IDX_VEC_C:    wr_ok = 1'b1;
            // timer control words keep only their compare enable
            `EMIG_IDX_TCTL_1:
            begin
                wr_tctl     = 1'b1;
                wr_tctl_num = 2'd0;
            end
            `EMIG_IDX_TCTL_2:
            begin
                wr_tctl     = 1'b1;
                wr_tctl_num = 2'd1;
            end
            `EMIG_IDX_TCTL_3:
            begin
                wr_tctl     = 1'b1;
                wr_tctl_num = 2'd2;
            end
            `EMIG_IDX_IRQ_STAT: wr_ok = 1'b1;
            `EMIG_IDX_IRQ_CLR:  wr_clr = 1'b1;
            `EMIG_IDX_IRQ_EN:   wr_en = 1'b1;
            default:            wr_ok = 1'b0;
        endcase
    end

    // per group mask, flags, request and vector
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : grp
            localparam [47:0] VALIDS = `EMIG_VALID_ALL;
            localparam [17:0] BASES  = `EMIG_ID_BASE_ALL;
            localparam [15:0] VALID  = VALIDS[g*16 +: 16];
            localparam [5:0]  BASE   = BASES[g*6 +: 6];
            reg  [15:0] mask;
            reg  [15:0] flag;
            reg  [5:0]  vec_id;
            wire [15:0] pend;
            wire [15:0] flag_clr;
            integer     i;

            // mask: lane-wise write, reserved bits stay zero
            always @(posedge aclk)
            begin
                if (!aresetn)
                    mask <= `EMIG_RST_16;
                else if (wr_fire && wr_mask_sel[g])
                    mask <= ((mask & ~byte_mask) | wr_bits) & VALID;
            end

            // flags: one clears, new event in same cycle wins
            assign flag_clr = (wr_fire && wr_flag_sel[g]) ? wr_bits : 16'h0000;
            always @(posedge aclk)
            begin
                if (!aresetn)
                    flag <= `EMIG_RST_16;
                else
                    flag <= ((flag & ~flag_clr) | evt_all[g*16 +: 16]) & VALID;
            end

            // a masked flag still latches; the mask gates the request and the vector
            assign pend             = flag & mask;
            assign group_irq_req[g] = |pend;

            // lowest pending bit wins since the loop ends on bit zero
            always @*
            begin
                vec_id = `EMIG_ID_NONE;
                for (i = 15; i >= 0; i = i - 1)
                    if (pend[i])
                        vec_id = BASE + i[5:0];
            end

            assign flag_all[g*16 +: 16] = flag;
            assign mask_all[g*16 +: 16] = mask;
            assign vec_all[g*6 +: 6]    = vec_id;
        end
    endgenerate

    // a group event is its request going high
    assign req_rise = group_irq_req & ~req_prev;
    assign irq      = |(irq_stat & irq_en);

    // timer compare enables, block interrupt registers
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tctl_cmp_en             <= 3'b000;
            irq_stat                <= 3'b000;
            irq_en                  <= 3'b000;
            req_prev                <= 3'b000;
            gp_timer_compare_action <= 3'b000;
        end
        else
        begin
            req_prev                <= group_irq_req;
            gp_timer_compare_action <= cmp_hit;
            if (wr_fire && wr_tctl && w_strb[0])
                tctl_cmp_en[wr_tctl_num] <= w_data[`EMIG_TCTL_CMP_EN];
            if (wr_fire && wr_en)
                irq_en <= (irq_en & ~byte_mask[2:0]) | wr_bits[2:0];
            // set beats clear so no request edge is lost
            if (wr_fire && wr_clr)
                irq_stat <= (irq_stat & ~wr_bits[2:0]) | req_rise;
            else
                irq_stat <= irq_stat | req_rise;
        end
    end

    // write address and data are taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held      <= 1'b0;
            aw_idx       <= 15'h0000;
            w_held       <= 1'b0;
            w_data       <= 16'h0000;
            w_strb       <= 2'b00;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EMIG_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_held)
            begin
                aw_held <= 1'b1;
                aw_idx  <= s_axi_awaddr[16:2];
            end
            if (s_axi_wvalid && !w_held)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata[15:0];
                w_strb <= s_axi_wstrb[1:0];
            end
            // a new write waits until the last answer has been taken
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `EMIG_RESP_OKAY : `EMIG_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // read decode; unmapped words answer slverr with zero data
    always @*
    begin
        rd_word = 16'h0000;
        rd_ok   = 1'b1;
        case (rd_idx)
            `EMIG_IDX_MASK_A:   rd_word = mask_all[15:0];
            `EMIG_IDX_MASK_B:   rd_word = mask_all[31:16];
            `EMIG_IDX_MASK_C:   rd_word = mask_all[47:32];
            `EMIG_IDX_FLAG_A:   rd_word = flag_all[15:0];
            `EMIG_IDX_FLAG_B:   rd_word = flag_all[31:16];
            `EMIG_IDX_FLAG_C:   rd_word = flag_all[47:32];
            `EMIG_IDX_VEC_A:    rd_word = {10'h000, vec_all[5:0]};
            `EMIG_IDX_VEC_B:    rd_word = {10'h000, vec_all[11:6]};
            `EMIG_IDX_VEC_C:    rd_word = {10'h000, vec_all[17:12]};
            `EMIG_IDX_TCTL_1:   rd_word = {14'h0000, tctl_cmp_en[0], 1'b0};
            `EMIG_IDX_TCTL_2:   rd_word = {14'h0000, tctl_cmp_en[1], 1'b0};
            `EMIG_IDX_TCTL_3:   rd_word = {14'h0000, tctl_cmp_en[2], 1'b0};
            `EMIG_IDX_IRQ_STAT: rd_word = {13'h0000, irq_stat};
            `EMIG_IDX_IRQ_CLR:  rd_word = 16'h0000;
            `EMIG_IDX_IRQ_EN:   rd_word = {13'h0000, irq_en};
            default:            rd_ok = 1'b0;
        endcase
    end

    // read answer is captured at the address handshake
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `EMIG_RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_word};
            s_axi_rresp  <= rd_ok ? `EMIG_RESP_OKAY : `EMIG_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule // emig_top
